// File: rtl/sdwt_defines.svh
// numeric constants shared by both ends of the dram link
`ifndef SDWT_DEFINES_SVH
`define SDWT_DEFINES_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SDWT_REG_CTRL   8'h00
`define SDWT_REG_CMD    8'h04
`define SDWT_REG_STAT   8'h08
`define SDWT_CTRL_RST   7'h00
// control register fields
`define SDWT_C_BL       1:0
`define SDWT_C_RTTNOM   2
`define SDWT_C_RTTWR    3
`define SDWT_C_ODT      4
`define SDWT_C_CKSTOP   5
`define SDWT_C_VREF     6
// command register fields
`define SDWT_F_OP       2:0
`define SDWT_F_BA       5:3
`define SDWT_F_ADDR     19:6
`define SDWT_F_SEED     31:24
// status register fields
`define SDWT_S_BUSY     0
`define SDWT_S_SR       1
`define SDWT_S_DLL      2
`define SDWT_S_REFUSED  3
`define SDWT_S_BANKS    15:8
// ----------------------------------------------------------------
// link encodings
// ----------------------------------------------------------------
`define SDWT_BL_FIX8    2'h0
`define SDWT_BL_OTF     2'h1
`define SDWT_BL_FIX4    2'h2
`define SDWT_A_CHOP     12
`define SDWT_A_ALL      10
`define SDWT_MR_FIRST   3'h0
`define SDWT_ZQ_LONG    14'h0400
// link clock divider: one link clock is eight system clocks
`define SDWT_DIV_LAST   3'h7
`define SDWT_HALF_LAST  2'h3
// ----------------------------------------------------------------
// timing, in link clock periods
// ----------------------------------------------------------------
`define SDWT_T_WTR      10'd4
`define SDWT_T_WR       10'd8
`define SDWT_T_RP       10'd5
`define SDWT_T_OTF      10'd2
`define SDWT_T_CKESR    10'd5
`define SDWT_T_CKSRE    10'd5
`define SDWT_T_CKSRX    10'd5
`define SDWT_T_XS       10'd20
`define SDWT_T_XSDLL    10'd64
`define SDWT_T_ZQOPER   10'd32
`define SDWT_T_VREF     10'd512
// write strobe schedule, in half link clocks
`define SDWT_H_PRE      4'h2
`define SDWT_H_DATA     4'h3
`define SDWT_BEATS8     4'h8
`define SDWT_BEATS4     4'h4
// device internal refresh spacing, in system clocks
`define SDWT_SR_REF_GAP 8'hc8
`endif

// File: rtl/sdwt_pkg.sv
// types and burst decode shared by both ends
`include "sdwt_defines.svh"
package sdwt_pkg;
	// {rasN, casN, weN} with chip select low
	typedef enum logic [2:0] {
		SDWT_CMD_MRS = 3'h0, SDWT_CMD_REF = 3'h1, SDWT_CMD_PRE = 3'h2,
		SDWT_CMD_ACT = 3'h3, SDWT_CMD_WR  = 3'h4, SDWT_CMD_RD  = 3'h5,
		SDWT_CMD_ZQ  = 3'h6, SDWT_CMD_NOP = 3'h7
	} sdwt_cmd_type;
	typedef enum logic [2:0] {
		SDWT_OP_MRS = 3'h0, SDWT_OP_ACT = 3'h1, SDWT_OP_WR  = 3'h2,
		SDWT_OP_RD  = 3'h3, SDWT_OP_PRE = 3'h4, SDWT_OP_SRE = 3'h5,
		SDWT_OP_SRX = 3'h6, SDWT_OP_ZQ  = 3'h7
	} sdwt_op_type;
	typedef enum logic [1:0] {
		SDWT_SR_RUN = 2'h0, SDWT_SR_IN = 2'h1,
		SDWT_SR_STOP = 2'h2, SDWT_SR_WAKE = 2'h3
	} sdwt_sr_type;
	typedef enum logic [1:0] {
		SDWT_CAP_IDLE = 2'h0, SDWT_CAP_PRE = 2'h1, SDWT_CAP_DATA = 2'h2
	} sdwt_cap_type;
	typedef struct packed {
		logic        ck;
		logic        cke;
		logic        csN;
		logic [2:0]  cmd;
		logic [13:0] addr;
		logic [2:0]  ba;
		logic        resetN;
		logic        dqs;
		logic [7:0]  dq;
	} sdwt_pins_type;
	// eight beats for fixed eight, or per-command select with chop bit high
	function automatic logic sdwt_is_eight(input logic [1:0] field,
			input logic chop);
		return (field == `SDWT_BL_FIX8) ||
			((field == `SDWT_BL_OTF) && chop);
	endfunction
endpackage

// File: rtl/sdwt_link_if.sv
// link between memory controller and dram device
`timescale 1ns/10ps
interface sdwt_link_if;
	logic        ck;
	logic        cke;
	logic        csN;
	logic        rasN;
	logic        casN;
	logic        weN;
	logic [13:0] addr;
	logic [2:0]  ba;
	logic        termination_control_input;
	logic        resetN;
	logic        dqs;
	logic        dqsOe;
	logic [7:0]  dq;
	logic        dqsLine;
	// an undriven strobe reads low
	assign dqsLine = dqsOe & dqs;
	modport ctrl (output ck, cke, csN, rasN, casN, weN, addr, ba, termination_control_input,
		resetN, dqs, dqsOe, dq);
	modport dev (input ck, cke, csN, rasN, casN, weN, addr, ba, termination_control_input,
		resetN, dqsLine, dq);
endinterface

// File: rtl/sdwt_device.sv
// dram device end: burst decode, precharge, self refresh, write capture
`timescale 1ns/10ps
`include "sdwt_defines.svh"
module sdwt_device (
	// system
	input  wire logic        clk,
	input  wire logic        srst,
	// link
	sdwt_link_if.dev         link,
	// user side
	output logic [1:0]       burstField,
	output logic [7:0]       bankOpen,
	output logic             inSelfRefresh,
	output logic             dllEnabled,
	output logic             dllResetPulse,
	output logic             refreshPulse,
	output logic             lastBurstEight,
	output logic [7:0]       wrData,
	output logic             wrValid,
	output logic             wrLast
);
	import sdwt_pkg::*;
	// ----------------------------------------------------------------
	// pin synchroniser
	// ----------------------------------------------------------------
	sdwt_pins_type rawIn;
	sdwt_pins_type s1_q;
	sdwt_pins_type pin;
	logic          ckPrev_q;
	logic          dqsPrev_q;
	logic          rise;
	logic          enterSr;
	logic          wrCmd;
	logic          eight;
	sdwt_cmd_type  cmd;
	sdwt_cap_type  cap_q;
	logic [3:0]    beatsLeft_q;
	logic [7:0]    refTimer_q;

	assign rawIn = '{ck: link.ck, cke: link.cke, csN: link.csN,
		cmd: {link.rasN, link.casN, link.weN}, addr: link.addr,
		ba: link.ba, resetN: link.resetN, dqs: link.dqsLine, dq: link.dq};

	// two stages; only the second one is looked at
	always_ff @(posedge clk) begin
		if (srst) begin
			s1_q <= '0;
			pin <= '0;
			ckPrev_q <= 1'b0;
			dqsPrev_q <= 1'b0;
		end else begin
			s1_q <= rawIn;
			pin <= s1_q;
			ckPrev_q <= pin.ck;
			dqsPrev_q <= pin.dqs;
		end
	end

	// command decode on the sampled link clock rising edge
	assign rise = pin.ck & ~ckPrev_q;
	assign cmd = sdwt_cmd_type'(pin.cmd);
	assign eight = sdwt_is_eight(burstField, pin.addr[`SDWT_A_CHOP]);
	assign enterSr = rise & ~inSelfRefresh & ~pin.csN &
		(cmd == SDWT_CMD_REF) & ~pin.cke;
	assign wrCmd = rise & ~inSelfRefresh & ~pin.csN & (cmd == SDWT_CMD_WR);

	// ----------------------------------------------------------------
	// command state
	// ----------------------------------------------------------------
	// reset pin low clears state even in self refresh
	always_ff @(posedge clk) begin
		dllResetPulse <= 1'b0;
		if (srst || !pin.resetN) begin
			burstField <= `SDWT_BL_FIX8;
			bankOpen <= 8'h00;
			inSelfRefresh <= 1'b0;
			dllEnabled <= 1'b1;
			lastBurstEight <= 1'b1;
		end else if (rise && inSelfRefresh) begin
			// only clock enable is watched here
			if (pin.cke) begin
				inSelfRefresh <= 1'b0;
				dllEnabled <= 1'b1;
				dllResetPulse <= 1'b1;
			end
		end else if (rise && !pin.csN) begin
			unique case (cmd)
				SDWT_CMD_MRS: begin
					if (pin.ba == `SDWT_MR_FIRST)
						burstField <= pin.addr[`SDWT_C_BL];
				end
				SDWT_CMD_REF: begin
					if (enterSr) begin
						inSelfRefresh <= 1'b1;
						dllEnabled <= 1'b0;
					end
				end
				SDWT_CMD_PRE: begin
					if (pin.addr[`SDWT_A_ALL])
						bankOpen <= 8'h00;
					else
						bankOpen[pin.ba] <= 1'b0;
				end
				SDWT_CMD_ACT: bankOpen[pin.ba] <= 1'b1;
				SDWT_CMD_WR, SDWT_CMD_RD: lastBurstEight <= eight;
				SDWT_CMD_ZQ, SDWT_CMD_NOP: begin
				end
			endcase
		end
	end

	// internal refresh: one at once on entry, then at a fixed spacing
	always_ff @(posedge clk) begin
		refreshPulse <= 1'b0;
		if (srst) begin
			refTimer_q <= 8'h00;
		end else if (enterSr) begin
			refreshPulse <= 1'b1;
			refTimer_q <= `SDWT_SR_REF_GAP;
		end else if (inSelfRefresh) begin
			if (refTimer_q == 8'h00) begin
				refreshPulse <= 1'b1;
				refTimer_q <= `SDWT_SR_REF_GAP;
			end else begin
				refTimer_q <= refTimer_q - 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// write data capture on strobe transitions
	// ----------------------------------------------------------------
	// the preamble fall arms capture, so the strobe's first rise is skipped
	always_ff @(posedge clk) begin
		wrValid <= 1'b0;
		wrLast <= 1'b0;
		if (srst) begin
			cap_q <= SDWT_CAP_IDLE;
			beatsLeft_q <= 4'h0;
			wrData <= 8'h00;
		end else if (wrCmd) begin
			cap_q <= SDWT_CAP_PRE;
			beatsLeft_q <= eight ? `SDWT_BEATS8 : `SDWT_BEATS4;
		end else begin
			unique case (cap_q)
				SDWT_CAP_IDLE: begin
				end
				SDWT_CAP_PRE: begin
					if (dqsPrev_q && !pin.dqs)
						cap_q <= SDWT_CAP_DATA;
				end
				SDWT_CAP_DATA: begin
					if (dqsPrev_q != pin.dqs) begin
						wrData <= pin.dq;
						wrValid <= 1'b1;
						beatsLeft_q <= beatsLeft_q - 4'h1;
						if (beatsLeft_q == 4'h1) begin
							cap_q <= SDWT_CAP_IDLE;
							wrLast <= 1'b1;
						end
					end
				end
				default: cap_q <= SDWT_CAP_IDLE;
			endcase
		end
	end
endmodule

// File: rtl/sdwt_controller.sv
// memory controller end: apb command port, link sequencing and timing
//
// Overview of operation
// - read waits write-to-read delay after last beat
// - per-command chop counts from full eight-beat slot
// - eight beats for field 00, or 01 with chop bit high
// - field 01, chop bit low: four-beat chop
// - field 10: every burst is four-beat chop
// - precharge waits write recovery after last beat
// - strobe high, low preamble, data, low postamble
// - all-bank bit picks one bank or all
// - read or write only to an activated bank
// - self refresh entry is refresh with enable low
// - device turns loop off in, resets on exit
// - floating reference: first write 512 clocks later
// - entry only with banks idle, no burst running
// - termination input low before entry unless unused
// - clock enable stays low throughout self refresh
// - device ignores all but enable and reset
// - device refreshes internally right after entry
// - stable clock: stay minimum residency before exit
// - stopped clock: entry hold, then exit valid time
// - only no-operation for exit-to-command time
// - long calibration and locked wait before locked commands
// - exit waits counted from first edge enable high
`timescale 1ns/10ps
`include "sdwt_defines.svh"
module sdwt_controller (
	// system
	input  wire logic        clk,
	input  wire logic        srst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// link
	sdwt_link_if.ctrl        link
);
	import sdwt_pkg::*;
	logic [6:0]         ctrl_q;
	logic [31:0]        cmd_q;
	logic               pend_q;
	logic               refused_q;
	logic [2:0]         ckDiv_q;
	logic               ckRun_q;
	logic [2:0]         cmdCode_q;
	logic               cke_q;
	logic [13:0]        addr_q;
	logic [2:0]         ba_q;
	logic               odt_q;
	logic               resetN_q;
	logic [7:0]         bankOpen_q;
	logic [1:0]         mrField_q;
	sdwt_sr_type        srState_q;
	logic               dllNeed_q;
	logic [9:0]         rp_q, gen_q, xs_q, dll_q, zq_q, vref_q, wtr_q, wr_q;
	logic               bursting_q;
	logic               otf_q;
	logic [3:0]         half_q;
	logic [3:0]         beats_q;
	logic [7:0]         seed_q;
	logic               dqs_q;
	logic               dqsOe_q;
	logic [7:0]         dq_q;
	logic [3:0]         nh;
	logic [31:0]        stat;
	logic               slot, halfLast, busy, srRun, xsDone, dllTimed;
	logic               termEn, ckStop, legal, ready, issue, issueWr;
	logic               apbWr, cmdWr;
	sdwt_op_type        op;
	logic [2:0]         bank;
	logic [13:0]        cAddr;

	function automatic logic [9:0] dec10(input logic [9:0] v);
		return (v == 10'd0) ? v : v - 10'd1;
	endfunction
	function automatic logic regMapped(input logic [7:0] a);
		return (a == `SDWT_REG_CTRL) || (a == `SDWT_REG_CMD) ||
			(a == `SDWT_REG_STAT);
	endfunction

	// ----------------------------------------------------------------
	// link clock divider
	// ----------------------------------------------------------------
	// command pins change at the end of a high phase, so they are settled
	// for a whole half clock before each rising edge
	always_ff @(posedge clk) begin
		if (srst)
			ckDiv_q <= 3'h0;
		else
			ckDiv_q <= ckDiv_q + 3'h1;
	end
	assign slot = (ckDiv_q == `SDWT_DIV_LAST);
	assign halfLast = (ckDiv_q[1:0] == `SDWT_HALF_LAST);

	// ----------------------------------------------------------------
	// apb slave, zero wait states
	// ----------------------------------------------------------------
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~regMapped(paddr);
	assign apbWr = psel & penable & pwrite;
	assign cmdWr = apbWr & (paddr == `SDWT_REG_CMD);
	assign busy = pend_q | bursting_q;

	// read data latched in the setup cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= `SDWT_CTRL_RST;
			prdata <= 32'h0;
		end else begin
			if (apbWr && paddr == `SDWT_REG_CTRL)
				ctrl_q <= pwdata[6:0];
			if (psel && !penable) begin
				unique case (paddr)
					`SDWT_REG_CTRL: prdata <= {25'h0, ctrl_q};
					`SDWT_REG_CMD: prdata <= cmd_q;
					`SDWT_REG_STAT: prdata <= stat;
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	always_comb begin
		stat = 32'h0;
		stat[`SDWT_S_BUSY] = busy;
		stat[`SDWT_S_SR] = ~srRun;
		stat[`SDWT_S_DLL] = ~dllNeed_q & dllTimed;
		stat[`SDWT_S_REFUSED] = refused_q;
		stat[`SDWT_S_BANKS] = bankOpen_q;
	end

	// ----------------------------------------------------------------
	// command checks
	// ----------------------------------------------------------------
	assign op = sdwt_op_type'(cmd_q[`SDWT_F_OP]);
	assign bank = cmd_q[`SDWT_F_BA];
	assign cAddr = cmd_q[`SDWT_F_ADDR];
	assign srRun = (srState_q == SDWT_SR_RUN);
	assign xsDone = (xs_q == 10'd0);
	assign dllTimed = (zq_q == 10'd0) && (dll_q == 10'd0);
	assign termEn = ctrl_q[`SDWT_C_RTTNOM] | ctrl_q[`SDWT_C_RTTWR];
	assign ckStop = ctrl_q[`SDWT_C_CKSTOP];

	// illegal orders are refused, timing waits simply hold the order
	always_comb begin
		legal = 1'b0;
		ready = 1'b0;
		unique case (op)
			SDWT_OP_MRS, SDWT_OP_ZQ: begin
				legal = srRun & ~|bankOpen_q;
				ready = xsDone;
			end
			SDWT_OP_ACT: begin
				legal = srRun & ~bankOpen_q[bank];
				ready = xsDone & (rp_q == 10'd0);
			end
			SDWT_OP_WR: begin
				legal = srRun & bankOpen_q[bank] & ~dllNeed_q;
				ready = xsDone & dllTimed & (vref_q == 10'd0);
			end
			SDWT_OP_RD: begin
				legal = srRun & bankOpen_q[bank] & ~dllNeed_q;
				ready = xsDone & dllTimed & (wtr_q == 10'd0);
			end
			SDWT_OP_PRE: begin
				legal = srRun;
				ready = xsDone & (wr_q == 10'd0);
			end
			SDWT_OP_SRE: begin
				legal = srRun & ~|bankOpen_q & ~bursting_q;
				ready = xsDone & (rp_q == 10'd0) & (wr_q == 10'd0) &
					(~odt_q | ~termEn);
			end
			SDWT_OP_SRX: begin
				legal = ~srRun;
				ready = (srState_q == SDWT_SR_STOP) ||
					(gen_q == 10'd0 && (srState_q == SDWT_SR_WAKE ||
					(srState_q == SDWT_SR_IN && !ckStop)));
			end
		endcase
	end
	assign issue = slot & pend_q & legal & ready;
	assign issueWr = issue & (op == SDWT_OP_WR);

	// ----------------------------------------------------------------
	// sequencer: one command slot per link clock
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			pend_q <= 1'b0;
			cmd_q <= 32'h0;
			refused_q <= 1'b0;
			ckRun_q <= 1'b1;
			cmdCode_q <= SDWT_CMD_NOP;
			cke_q <= 1'b0;
			addr_q <= 14'h0;
			ba_q <= 3'h0;
			odt_q <= 1'b0;
			resetN_q <= 1'b0;
			bankOpen_q <= 8'h00;
			mrField_q <= `SDWT_BL_FIX8;
			srState_q <= SDWT_SR_RUN;
			dllNeed_q <= 1'b0;
			{rp_q, gen_q, xs_q, dll_q, zq_q, vref_q} <= '0;
		end else begin
			resetN_q <= 1'b1;
			cke_q <= cke_q | srRun;
			if (apbWr && paddr == `SDWT_REG_STAT && pwdata[`SDWT_S_REFUSED])
				refused_q <= 1'b0;
			if (cmdWr && !busy) begin
				pend_q <= 1'b1;
				cmd_q <= pwdata;
			end else if (cmdWr) begin
				refused_q <= 1'b1;
			end
			if (slot) begin
				cmdCode_q <= SDWT_CMD_NOP;
				rp_q <= dec10(rp_q);
				gen_q <= dec10(gen_q);
				xs_q <= dec10(xs_q);
				dll_q <= dec10(dll_q);
				zq_q <= dec10(zq_q);
				vref_q <= dec10(vref_q);
				odt_q <= ctrl_q[`SDWT_C_ODT] & srRun & ~dllNeed_q &
					(dll_q == 10'd0) &
					~(pend_q & (op == SDWT_OP_SRE));
				if (srState_q == SDWT_SR_IN && ckStop && gen_q == 10'd0) begin
					ckRun_q <= 1'b0;
					srState_q <= SDWT_SR_STOP;
				end
				if (pend_q && !legal) begin
					pend_q <= 1'b0;
					refused_q <= 1'b1;
				end
			end
			if (issue) begin
				pend_q <= 1'b0;
				ba_q <= bank;
				addr_q <= cAddr;
				unique case (op)
					SDWT_OP_MRS: begin
						cmdCode_q <= SDWT_CMD_MRS;
						ba_q <= `SDWT_MR_FIRST;
						addr_q <= 14'(ctrl_q[`SDWT_C_BL]);
						mrField_q <= ctrl_q[`SDWT_C_BL];
					end
					SDWT_OP_ACT: begin
						cmdCode_q <= SDWT_CMD_ACT;
						bankOpen_q[bank] <= 1'b1;
					end
					SDWT_OP_WR: cmdCode_q <= SDWT_CMD_WR;
					SDWT_OP_RD: cmdCode_q <= SDWT_CMD_RD;
					SDWT_OP_PRE: begin
						cmdCode_q <= SDWT_CMD_PRE;
						rp_q <= `SDWT_T_RP;
						if (cAddr[`SDWT_A_ALL])
							bankOpen_q <= 8'h00;
						else
							bankOpen_q[bank] <= 1'b0;
					end
					SDWT_OP_SRE: begin
						cmdCode_q <= SDWT_CMD_REF;
						cke_q <= 1'b0;
						srState_q <= SDWT_SR_IN;
						gen_q <= ckStop ? `SDWT_T_CKSRE : `SDWT_T_CKESR;
					end
					SDWT_OP_SRX: begin
						if (srState_q == SDWT_SR_STOP) begin
							pend_q <= 1'b1;
							ckRun_q <= 1'b1;
							gen_q <= `SDWT_T_CKSRX;
							srState_q <= SDWT_SR_WAKE;
						end else begin
							cke_q <= 1'b1;
							srState_q <= SDWT_SR_RUN;
							xs_q <= `SDWT_T_XS;
							dll_q <= `SDWT_T_XSDLL;
							dllNeed_q <= 1'b1;
							vref_q <= ctrl_q[`SDWT_C_VREF] ? `SDWT_T_VREF :
								10'd0;
						end
					end
					SDWT_OP_ZQ: begin
						cmdCode_q <= SDWT_CMD_ZQ;
						addr_q <= `SDWT_ZQ_LONG;
						zq_q <= `SDWT_T_ZQOPER;
						dllNeed_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// write strobe and data, in half link clocks
	// ----------------------------------------------------------------
	assign nh = half_q + 4'h1;

	// recovery timers start after the burst; a per-command chop still
	// occupies the whole eight-beat slot
	always_ff @(posedge clk) begin
		if (srst) begin
			bursting_q <= 1'b0;
			{half_q, beats_q, seed_q, dq_q} <= '0;
			{otf_q, dqs_q, dqsOe_q} <= '0;
			{wtr_q, wr_q} <= '0;
		end else begin
			if (slot) begin
				wtr_q <= dec10(wtr_q);
				wr_q <= dec10(wr_q);
			end
			if (halfLast && issueWr) begin
				bursting_q <= 1'b1;
				half_q <= 4'h0;
				dqsOe_q <= 1'b1;
				dqs_q <= 1'b1;
				seed_q <= cmd_q[`SDWT_F_SEED];
				beats_q <= sdwt_is_eight(mrField_q, cAddr[`SDWT_A_CHOP]) ?
					`SDWT_BEATS8 : `SDWT_BEATS4;
				otf_q <= (mrField_q == `SDWT_BL_OTF) & ~cAddr[`SDWT_A_CHOP];
			end else if (halfLast && bursting_q) begin
				half_q <= nh;
				if (nh < `SDWT_H_DATA) begin
					dqs_q <= (nh != `SDWT_H_PRE);
				end else if (nh < `SDWT_H_DATA + beats_q) begin
					dqs_q <= nh[0];
					dq_q <= seed_q + 8'(nh - `SDWT_H_DATA);
				end else if (nh == `SDWT_H_DATA + beats_q) begin
					dqs_q <= 1'b0;
				end else begin
					dqsOe_q <= 1'b0;
					bursting_q <= 1'b0;
					wtr_q <= `SDWT_T_WTR + (otf_q ? `SDWT_T_OTF : 10'd0);
					wr_q <= `SDWT_T_WR + (otf_q ? `SDWT_T_OTF : 10'd0);
				end
			end
		end
	end

	// link pins
	assign link.ck = ckRun_q & ckDiv_q[2];
	assign link.cke = cke_q;
	assign link.csN = 1'b0;
	assign {link.rasN, link.casN, link.weN} = cmdCode_q;
	assign link.addr = addr_q;
	assign link.ba = ba_q;
	assign link.termination_control_input = odt_q;
	assign link.resetN = resetN_q;
	assign link.dqs = dqs_q;
	assign link.dqsOe = dqsOe_q;
	assign link.dq = dq_q;
endmodule

// File: tb/sdwt_link_monitor.sv
// link checker: strobe shape, self refresh entry and exit, write spacing
`timescale 1ns/10ps
module sdwt_link_monitor (
	// system
	input wire logic clk,
	input wire logic srst,
	// link
	input wire logic cke,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic termination_control_input,
	input wire logic dqs,
	input wire logic dqsOe
);
	logic [2:0] cmdNow;
	logic       ckeLast_q;
	logic       srSeen_q;
	logic [9:0] exitAge_q;
	logic [7:0] lowAge_q;
	logic [7:0] wrAge_q;
	assign cmdNow = {rasN, casN, weN};
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// self refresh seen: only exits after it get the exit windows
	always_ff @(posedge clk) begin
		ckeLast_q <= cke;
		srSeen_q <= srst ? 1'b0 : (srSeen_q | (ckeLast_q & ~cke));
	end
	// ages: since enable rose, enable low, end of write command
	always_ff @(posedge clk) begin
		// starts saturated, so leaving reset opens no exit window
		if (srst) exitAge_q <= 10'h3ff;
		else if (cke & ~ckeLast_q & srSeen_q) exitAge_q <= 10'd0;
		else if (exitAge_q != 10'h3ff) exitAge_q <= exitAge_q + 10'd1;
		if (srst | cke) lowAge_q <= 8'd0;
		else if (lowAge_q != 8'hff) lowAge_q <= lowAge_q + 8'd1;
		if (srst) wrAge_q <= 8'hff;
		else if (cmdNow == 3'h4) wrAge_q <= 8'd0;
		else if (wrAge_q != 8'hff) wrAge_q <= wrAge_q + 8'd1;
	end
	pre_strobe_a: assert property ($rose(dqsOe) |-> dqs [*8] ##1 !dqs [*4])
		else $error("write preamble shape wrong");
	post_strobe_a: assert property ($fell(dqsOe) |-> !$past(dqs) && !$past(dqs, 4))
		else $error("write postamble not low");
	entry_refresh_a: assert property ($fell(cke) |-> cmdNow == 3'h1)
		else $error("enable fell without refresh");
	entry_odt_a: assert property ($fell(cke) |-> !termination_control_input)
		else $error("termination high at entry");
	entry_idle_a: assert property ($fell(cke) |-> !dqsOe)
		else $error("entry during write burst");
	residency_min_a: assert property ($rose(cke) && srSeen_q |-> lowAge_q >= 8'd40)
		else $error("self refresh left too early");
	exit_nop_a: assert property (exitAge_q < 10'd160 |-> cmdNow == 3'h7)
		else $error("command inside exit window");
	exit_odt_a: assert property (exitAge_q < 10'd512 |-> !termination_control_input)
		else $error("termination on before lock");
	wr_rd_a: assert property ($changed(cmdNow) && cmdNow == 3'h5 |-> wrAge_q >= 8'd48)
		else $error("read too soon after write");
	wr_pre_a: assert property ($changed(cmdNow) && cmdNow == 3'h2 |-> wrAge_q >= 8'd80)
		else $error("precharge too soon after write");
endmodule

// File: tb/sdram_write_turnaround_self_refresh_bench.sv
// self-checking bench: both link ends joined, driven over apb
`timescale 1ns/10ps
`include "sdwt_defines.svh"
`define CHK(got, exp) begin \
	samplesChecked++; \
	if ((got) !== (exp)) begin \
		errCount++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
	end \
end
module sdram_write_turnaround_self_refresh_bench;
	import sdwt_pkg::*;
	logic        clk, srst, psel, penable, pwrite, pready, pslverr;
	logic        inSelfRefresh, dllEnabled, lastBurstEight, wrValid, wrLast;
	logic [7:0]  paddr, bankOpen, wrData, seed;
	logic [31:0] pwdata, prdata, rd;
	logic [34:0] expQ[$], maskQ[$], m, e;
	logic [25:0] beatQ[$], beatGot;
	logic [3:0]  beatCnt;
	logic [2:0]  b;
	logic        chop, refreshPulse, dllResetPulse, refSeen;
	logic [1:0]  burstField, dllCnt;
	int          errCount, samplesChecked, bl, s;
	sdwt_link_if u_sdwt_link_if();
	sdwt_controller u_sdwt_controller (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(u_sdwt_link_if));
	sdwt_device u_sdwt_device (.clk(clk), .srst(srst), .link(u_sdwt_link_if),
		.burstField(burstField), .bankOpen(bankOpen),
		.inSelfRefresh(inSelfRefresh), .dllEnabled(dllEnabled),
		.dllResetPulse(dllResetPulse), .refreshPulse(refreshPulse),
		.lastBurstEight(lastBurstEight), .wrData(wrData), .wrValid(wrValid),
		.wrLast(wrLast));
	sdwt_link_monitor u_sdwt_link_monitor (.clk(clk), .srst(srst),
		.cke(u_sdwt_link_if.cke), .rasN(u_sdwt_link_if.rasN),
		.casN(u_sdwt_link_if.casN), .weN(u_sdwt_link_if.weN),
		.termination_control_input(u_sdwt_link_if.termination_control_input), .dqs(u_sdwt_link_if.dqs),
		.dqsOe(u_sdwt_link_if.dqsOe));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task completeRun;
		if (errCount == 0 && samplesChecked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// one apb transfer, held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		if (n >= 50) begin
			errCount++;
			completeRun();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// a read whose masked result the watcher compares
	task automatic check(input logic [7:0] a, input logic [34:0] mk,
			input logic [34:0] ex);
		maskQ.push_back(mk);
		expQ.push_back(ex);
		apb(1'b0, a, 32'h0);
	endtask
	// poll busy; a zero mask tells the watcher to skip the note
	task automatic idle;
		int n;
		n = 0;
		do begin
			check(`SDWT_REG_STAT, 35'h0, 35'h0);
			n++;
		end while (rd[`SDWT_S_BUSY] !== 1'b0 && n < 5000);
		if (n >= 5000) begin
			errCount++;
			completeRun();
		end
	endtask
	task automatic cmd(input logic [2:0] op, input logic [2:0] ba,
			input logic [13:0] ad, input logic [7:0] sd);
		idle();
		apb(1'b1, `SDWT_REG_CMD, {sd, 4'h0, ad, ba, op});
	endtask
	// write burst: note open banks, exits so far, refresh seen, field,
	// burst kind, beat count and last byte
	task automatic wr_burst(input int f, input logic [2:0] ba, input logic c,
			input logic [7:0] sd, input logic [1:0] ex, input logic [7:0] bk);
		logic       eight;
		logic [3:0] beats;
		eight = (f == 0) || (f == 1 && c);
		beats = eight ? 4'h8 : 4'h4;
		beatQ.push_back({bk, ex, ex != 2'h0, 2'(f), eight, beats,
			sd + {4'h0, beats} - 8'h1});
		cmd(SDWT_OP_WR, ba, {1'b0, c, 12'h0}, sd);
	endtask
	// watcher: apb read results against the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
			m = maskQ.pop_front();
			e = expQ.pop_front();
			if (m != 35'h0) `CHK({inSelfRefresh, dllEnabled, pslverr, prdata} & m, e)
		end
	end
	// watcher: captured beats; count and last byte on the final one
	always @(posedge clk) begin
		if (wrValid === 1'b1) begin
			beatCnt <= (wrLast === 1'b1) ? 4'h0 : beatCnt + 4'h1;
			beatGot = {bankOpen, dllCnt, refSeen, burstField, lastBurstEight,
				beatCnt + 4'h1, wrData};
			if (wrLast === 1'b1) `CHK(beatGot, beatQ.pop_front())
		end
	end
	// watcher: loop resets and internal refreshes the device reports
	always @(posedge clk) begin
		if (srst) begin
			dllCnt <= 2'h0;
			refSeen <= 1'b0;
		end else begin
			if (dllResetPulse === 1'b1) dllCnt <= dllCnt + 2'h1;
			if (refreshPulse === 1'b1) refSeen <= 1'b1;
		end
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, beatCnt} = '0;
		srst = 1'b1;
		errCount = 0;
		samplesChecked = 0;
		void'($urandom(32'hdcfea173));
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		check(8'h0c, {3'h1, 32'hffffffff}, {3'h1, 32'h0});
		// every burst field, single and all-bank precharge, closed bank read
		for (bl = 0; bl < 3; bl++) begin
			b = 3'($urandom_range(7, 0));
			chop = 1'($urandom_range(1, 0));
			seed = 8'($urandom);
			apb(1'b1, `SDWT_REG_CTRL, 32'(bl));
			cmd(SDWT_OP_MRS, 3'h0, 14'(bl), 8'h0);
			cmd(SDWT_OP_ACT, b, 14'h0, 8'h0);
			cmd(SDWT_OP_ACT, b ^ 3'h1, 14'h0, 8'h0);
			wr_burst(bl, b, chop, seed, 2'h0,
				(8'h01 << b) | (8'h01 << (b ^ 3'h1)));
			cmd(SDWT_OP_RD, b, {1'b0, chop, 12'h0}, 8'h0);
			cmd(SDWT_OP_PRE, b ^ 3'h1, 14'h0, 8'h0);
			idle();
			check(`SDWT_REG_STAT, 35'hff08, {19'h0, 8'h01 << b, 8'h0});
			cmd(SDWT_OP_PRE, b ^ 3'h1, 14'h0400, 8'h0);
			cmd(SDWT_OP_RD, b, 14'h0, 8'h0);
			idle();
			check(`SDWT_REG_STAT, 35'hff08, 35'h8);
			apb(1'b1, `SDWT_REG_STAT, 32'h8);
		end
		// self refresh with running and with stopped clock
		for (s = 0; s < 2; s++) begin
			apb(1'b1, `SDWT_REG_CTRL, {25'h0, s[0], s[0], 5'h14});
			cmd(SDWT_OP_SRE, 3'h0, 14'h0, 8'h0);
			cmd(SDWT_OP_ACT, 3'h0, 14'h0, 8'h0);
			idle();
			check(`SDWT_REG_STAT, 35'h60000000a, 35'h40000000a);
			apb(1'b1, `SDWT_REG_STAT, 32'h8);
			cmd(SDWT_OP_SRX, 3'h0, 14'h0, 8'h0);
			cmd(SDWT_OP_ZQ, 3'h0, `SDWT_ZQ_LONG, 8'h0);
			cmd(SDWT_OP_ACT, 3'h2, 14'h0, 8'h0);
			wr_burst(2, 3'h2, 1'b1, 8'($urandom), 2'(s + 1), 8'h04);
			cmd(SDWT_OP_PRE, 3'h0, 14'h0400, 8'h0);
			idle();
			check(`SDWT_REG_STAT, 35'h60000ff0a, 35'h200000000);
		end
		completeRun();
	end
endmodule
